//--- hdl/spl_pkg.sv
// Package for sector protect lock logic: register map, fields, resets, timing
//
// Overview of operation
// - One volatile lock bit; zero freezes all nonvolatile guards, one permits change.
// - Lock clear command drives the lock bit to zero.
// - Persistent mode: lock set at reset; no command sets it again.
// - Software reset leaves the lock bit untouched.
// - Password mode: lock cleared at reset; only good unlock sets it.
// - Sector unprotected only when nonvolatile and volatile guards are both one.
// - Lock zero blocks nonvolatile guard changes, volatile guard changes still accepted.
// - Any reset returns all volatile guards to unprotected.
// - Nonvolatile guards survive hardware and software resets; changed only by program, erase or nrst.
// - Full 64-bit compare; every 64-bit pattern is a legal password.
// - After password mode selection, password read and program are ignored.
// - Password program only clears bits; ones over zeros stay zero silently.
// - Password is all ones before programming, in its own storage.
// - Mismatch sets program error, keeps busy set, lock unchanged.
// - Unlock attempts accepted no faster than one per 100 us.
// - Matching password skips delay and clears busy at once.
// - ECC status for every sector whatever its guards; read protect forces boot sector.
// - Protection mode selection bits can never be erased.
// - Lock zero: nonvolatile program or erase fails, altering no bit.
// - Mode field 11 default, 10 persistent, 01 password; 00 programming fails.
// - Volatile write clears a guard to protect, sets it to unprotect.
package spl_pkg;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_SECTOR   = 8'h08;
  localparam logic [7:0] ADDR_PWD_LO   = 8'h0c;
  localparam logic [7:0] ADDR_PWD_HI   = 8'h10;
  localparam logic [7:0] ADDR_CMD      = 8'h14;
  localparam logic [7:0] ADDR_MODE     = 8'h18;
  localparam logic [7:0] ADDR_ECC      = 8'h1c;
  localparam logic [7:0] ADDR_PROTMAP  = 8'h20;

  // Command codes written to ADDR_CMD
  localparam logic [3:0] CMD_LOCK_CLEAR = 4'h1;
  localparam logic [3:0] CMD_NV_PROGRAM = 4'h2;
  localparam logic [3:0] CMD_NV_ERASE   = 4'h3;
  localparam logic [3:0] CMD_VOL_WRITE  = 4'h4;
  localparam logic [3:0] CMD_PWD_PROG   = 4'h5;
  localparam logic [3:0] CMD_PWD_READ   = 4'h6;
  localparam logic [3:0] CMD_UNLOCK     = 4'h7;
  localparam logic [3:0] CMD_MODE_PROG  = 4'h8;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h9;
  localparam logic [3:0] CMD_CLEAR_ERR  = 4'ha;

  // Command register fields
  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_VAL_BIT   = 4;
  localparam int CMD_SEC_LSB   = 8;
  localparam int CMD_MODE_LSB  = 16;

  // Status register bits
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_PERR_BIT   = 1;
  localparam int ST_LOCK_BIT   = 2;
  localparam int ST_MODE_LSB   = 3;

  localparam logic [1:0] MODE_DEFAULT    = 2'h3;
  localparam logic [1:0] MODE_PERSISTENT = 2'h2;
  localparam logic [1:0] MODE_PASSWORD   = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL    = 2'h0;

  localparam logic [63:0] PWD_RESET = 64'hffffffffffffffff;

  // Unlock spacing; 100 us nominal, lower end of tolerance is 80 us
  localparam int UNLOCK_GAP_NS  = 100000;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int UNLOCK_GAP_CYC = (UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SPL_IDLE    = 2'b00,
    SPL_WAIT    = 2'b01,
    SPL_FAILED  = 2'b10
  } spl_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spl_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } spl_apb_rsp_s;
endpackage

//--- hdl/spl_sector_protect.sv
// Sector protection lock logic with APB register access
`timescale 1ns/1ps
module spl_sector_protect #(
  parameter int NUM_SECTORS    = 32,
  parameter int UNLOCK_GAP_CYC = spl_pkg::UNLOCK_GAP_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   hwResetN,
  input  wire spl_pkg::spl_apb_req_s  apbReq,
  output      spl_pkg::spl_apb_rsp_s  apbRsp,
  input  wire logic                   readProtectActive,
  input  wire logic [4:0]             eccAccessSector,
  input  wire logic [NUM_SECTORS-1:0] eccSectorFlags,
  output      logic [NUM_SECTORS-1:0] sectorWritable
);
  localparam int SW = $clog2(NUM_SECTORS);

  typedef struct packed {
    logic [NUM_SECTORS-1:0] nvGuard;
    logic [NUM_SECTORS-1:0] volGuard;
    logic                   guardLock;
    logic [1:0]             protMode;
    logic [63:0]            password;
    logic [63:0]            pwdBuf;
    logic [31:0]            rdData;
    logic                   busy;
    logic                   progErr;
    logic [31:0]            gapCnt;
    spl_pkg::spl_state_e    state;
    logic                   started;
  } spl_state_s;

  spl_state_s cur_q;
  spl_state_s nxt_d;

  logic       wrAcc;
  logic       rdAcc;
  logic [3:0] cmdCode;
  logic [SW-1:0] cmdSec;
  logic       cmdVal;
  logic       pwdMode;
  logic       eccSecOk;
  logic [SW-1:0] eccSec;

  assign wrAcc   = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign rdAcc   = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
  assign cmdCode = apbReq.pwdata[spl_pkg::CMD_CODE_LSB +: 4];
  assign cmdSec  = apbReq.pwdata[spl_pkg::CMD_SEC_LSB +: SW];
  assign cmdVal  = apbReq.pwdata[spl_pkg::CMD_VAL_BIT];
  assign pwdMode = (cur_q.protMode == spl_pkg::MODE_PASSWORD);

  // Read protection forces the boot sector
  assign eccSec   = readProtectActive ? '0 : eccAccessSector[SW-1:0];
  assign eccSecOk = cur_q.nvGuard[eccSec] & cur_q.volGuard[eccSec] | 1'b1;

  assign sectorWritable = cur_q.nvGuard & cur_q.volGuard;

  always_comb begin
    nxt_d = cur_q;
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = 1'b0;
    apbRsp.prdata  = cur_q.rdData;

    // Unlock attempts are spaced; a good password starts no wait
    unique case (cur_q.state)
      spl_pkg::SPL_IDLE: begin
      end
      spl_pkg::SPL_WAIT: begin
        if (cur_q.gapCnt == 32'h00000000) begin
          nxt_d.state = spl_pkg::SPL_IDLE;
          nxt_d.busy  = 1'b0;
        end else begin
          nxt_d.gapCnt = cur_q.gapCnt - 32'h00000001;
        end
      end
      spl_pkg::SPL_FAILED: begin
        // Busy stays set after a mismatch until error is cleared and the spacing has run out
        nxt_d.busy = 1'b1;
      end
    endcase

    if (rdAcc) begin
      case (apbReq.paddr)
        spl_pkg::ADDR_STATUS: begin
          apbRsp.prdata = '0;
          apbRsp.prdata[spl_pkg::ST_BUSY_BIT] = cur_q.busy;
          apbRsp.prdata[spl_pkg::ST_PERR_BIT] = cur_q.progErr;
          apbRsp.prdata[spl_pkg::ST_LOCK_BIT] = cur_q.guardLock;
          apbRsp.prdata[spl_pkg::ST_MODE_LSB +: 2] = cur_q.protMode;
        end
        spl_pkg::ADDR_SECTOR:  apbRsp.prdata = 32'(cur_q.nvGuard);
        spl_pkg::ADDR_PROTMAP: apbRsp.prdata = 32'(cur_q.volGuard);
        spl_pkg::ADDR_PWD_LO:  apbRsp.prdata = cur_q.pwdBuf[31:0];
        spl_pkg::ADDR_PWD_HI:  apbRsp.prdata = cur_q.pwdBuf[63:32];
        spl_pkg::ADDR_MODE:    apbRsp.prdata = {30'h00000000, cur_q.protMode};
        spl_pkg::ADDR_ECC:     apbRsp.prdata = {31'h00000000, eccSecOk & eccSectorFlags[eccSec]};
        spl_pkg::ADDR_CTRL:    apbRsp.prdata = '0;
        spl_pkg::ADDR_CMD:     apbRsp.prdata = '0;
        default:               apbRsp.pslverr = 1'b1;
      endcase
    end

    if (wrAcc) begin
      case (apbReq.paddr)
        spl_pkg::ADDR_PWD_LO: begin
          nxt_d.pwdBuf[31:0] = apbReq.pwdata;
          nxt_d.started = 1'b1;
        end
        spl_pkg::ADDR_PWD_HI: begin
          nxt_d.pwdBuf[63:32] = apbReq.pwdata;
        end
        spl_pkg::ADDR_CTRL: begin
          // Aborting a half-loaded password leaves lock state alone
          nxt_d.started = 1'b0;
        end
        spl_pkg::ADDR_CMD: begin
          if (!cur_q.busy) begin
            unique case (cmdCode)
              spl_pkg::CMD_LOCK_CLEAR: nxt_d.guardLock = 1'b0;
              spl_pkg::CMD_NV_PROGRAM: begin
                // Lock zero refuses; only the sector's bit is cleared otherwise
                if (cur_q.guardLock) begin
                  nxt_d.nvGuard[cmdSec] = 1'b0;
                end else begin
                  nxt_d.progErr = 1'b1;
                end
              end
              spl_pkg::CMD_NV_ERASE: begin
                if (cur_q.guardLock) begin
                  nxt_d.nvGuard = '1;
                end else begin
                  nxt_d.progErr = 1'b1;
                end
              end
              spl_pkg::CMD_VOL_WRITE: nxt_d.volGuard[cmdSec] = cmdVal;
              spl_pkg::CMD_PWD_PROG: begin
                if (cur_q.protMode != spl_pkg::MODE_PASSWORD) begin
                  nxt_d.password = cur_q.password & cur_q.pwdBuf;
                end
              end
              spl_pkg::CMD_PWD_READ: begin
                if (cur_q.protMode != spl_pkg::MODE_PASSWORD) begin
                  nxt_d.rdData = cur_q.password[31:0];
                  nxt_d.pwdBuf = cur_q.password;
                end
              end
              spl_pkg::CMD_UNLOCK: begin
                if (pwdMode && cur_q.started) begin
                  nxt_d.started = 1'b0;
                  nxt_d.busy = 1'b1;
                  if (cur_q.pwdBuf == cur_q.password) begin
                    nxt_d.guardLock = 1'b1;
                    nxt_d.busy = 1'b0;
                  end else begin
                    nxt_d.progErr = 1'b1;
                    nxt_d.state = spl_pkg::SPL_FAILED;
                    nxt_d.gapCnt = 32'(UNLOCK_GAP_CYC - 1);
                  end
                end
              end
              spl_pkg::CMD_MODE_PROG: begin
                // One-time bits: only ones may go to zero, never back
                if (cur_q.protMode != spl_pkg::MODE_DEFAULT) begin
                  nxt_d.progErr = 1'b1;
                end else if (apbReq.pwdata[spl_pkg::CMD_MODE_LSB +: 2] == spl_pkg::MODE_ILLEGAL) begin
                  nxt_d.progErr = 1'b1;
                end else begin
                  nxt_d.protMode = cur_q.protMode & apbReq.pwdata[spl_pkg::CMD_MODE_LSB +: 2];
                end
              end
              spl_pkg::CMD_SOFT_RESET: begin
                nxt_d.volGuard = '1;
                nxt_d.progErr = 1'b0;
                // Lock bit deliberately kept
                nxt_d.guardLock = cur_q.guardLock;
              end
              spl_pkg::CMD_CLEAR_ERR: nxt_d.progErr = 1'b0;
              default: nxt_d.progErr = cur_q.progErr;
            endcase
          end else if (cmdCode == spl_pkg::CMD_CLEAR_ERR && cur_q.state == spl_pkg::SPL_FAILED) begin
            // Error clear releases busy once the spacing has run out
            nxt_d.progErr = 1'b0;
            nxt_d.state = spl_pkg::SPL_WAIT;
          end
        end
        default: nxt_d.pwdBuf = cur_q.pwdBuf;
      endcase
    end

    if (cur_q.state == spl_pkg::SPL_FAILED && cur_q.gapCnt != 32'h00000000) begin
      nxt_d.gapCnt = cur_q.gapCnt - 32'h00000001;
    end

    // Hardware reset acts like power-on for lock and volatile guards
    if (!hwResetN) begin
      nxt_d.volGuard  = '1;
      nxt_d.guardLock = (cur_q.protMode != spl_pkg::MODE_PASSWORD);
      nxt_d.busy      = 1'b0;
      nxt_d.progErr   = 1'b0;
      nxt_d.state     = spl_pkg::SPL_IDLE;
      nxt_d.started   = 1'b0;
    end
  end

  // Nonvolatile contents stand in for array storage and are not hit by hwResetN
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur_q.nvGuard   <= '1;
      cur_q.volGuard  <= '1;
      cur_q.guardLock <= 1'b1;
      cur_q.protMode  <= spl_pkg::MODE_DEFAULT;
      cur_q.password  <= spl_pkg::PWD_RESET;
      cur_q.pwdBuf    <= '0;
      cur_q.rdData    <= '0;
      cur_q.busy      <= 1'b0;
      cur_q.progErr   <= 1'b0;
      cur_q.gapCnt    <= '0;
      cur_q.state     <= spl_pkg::SPL_IDLE;
      cur_q.started   <= 1'b0;
    end else begin
      cur_q <= nxt_d;
    end
  end
endmodule

//--- tb/spl_sector_protect_chk.sv
// Port checker for the sector protect lock block
`timescale 1ns/1ps
module spl_sector_protect_chk #(
  parameter int NUM_SECTORS = 32
) (
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  input wire logic                   hwResetN,
  input wire spl_pkg::spl_apb_req_s  apbReq,
  input wire spl_pkg::spl_apb_rsp_s  apbRsp,
  input wire logic                   readProtectActive,
  input wire logic [4:0]             eccAccessSector,
  input wire logic [NUM_SECTORS-1:0] eccSectorFlags,
  input wire logic [NUM_SECTORS-1:0] sectorWritable
);
  logic        acc;
  logic [31:0] d;
  logic        seenClear_q;
  assign acc = apbReq.psel && apbReq.penable;
  assign d   = apbRsp.prdata;
  function automatic logic rd(input logic [7:0] a);
    return acc && !apbReq.pwrite && apbReq.paddr == a;
  endfunction
  function automatic logic wc(input logic [3:0] c);
    return acc && apbReq.pwrite && apbReq.paddr == spl_pkg::ADDR_CMD && apbReq.pwdata[3:0] == c;
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Lock seen clear outside password mode; only a hardware reset or nrst may end that
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) seenClear_q <= 1'b0;
    else if (!hwResetN) seenClear_q <= 1'b0;
    else if (rd(spl_pkg::ADDR_STATUS) && !d[2] && d[4:3] != spl_pkg::MODE_PASSWORD) seenClear_q <= 1'b1;
  end
  a_lock_clear_cmd: assert property (
    wc(spl_pkg::CMD_LOCK_CLEAR) ##[1:10] rd(spl_pkg::ADDR_STATUS) |-> !d[2]) else $error("lock set after clear");
  a_lock_stays_clear: assert property (
    rd(spl_pkg::ADDR_STATUS) && seenClear_q && hwResetN && d[4:3] != spl_pkg::MODE_PASSWORD |-> !d[2])
    else $error("lock set again without reset");
  a_hw_vol_unprot: assert property (
    $rose(hwResetN) ##[0:8] rd(spl_pkg::ADDR_SECTOR) |-> d == sectorWritable) else $error("volatile guard kept");
  a_writable_both: assert property (
    rd(spl_pkg::ADDR_PROTMAP) ##3 rd(spl_pkg::ADDR_SECTOR) |-> (d & $past(d, 3)) == sectorWritable)
    else $error("writable not and of guards");
  a_ecc_boot_force: assert property (
    rd(spl_pkg::ADDR_ECC) && readProtectActive |-> d[0] == eccSectorFlags[0]) else $error("ecc not boot sector");
  a_ecc_sector_sel: assert property (
    rd(spl_pkg::ADDR_ECC) && !readProtectActive |-> d[0] == eccSectorFlags[eccAccessSector])
    else $error("ecc wrong sector");
  a_unmapped_err: assert property (
    acc && !apbReq.pwrite |-> apbRsp.pslverr == (apbReq.paddr > 8'h20 || apbReq.paddr[1:0] != 2'h0))
    else $error("slave error wrong");
  a_soft_reset_vol: assert property (
    wc(spl_pkg::CMD_SOFT_RESET) ##[1:4] rd(spl_pkg::ADDR_PROTMAP) |-> &d[NUM_SECTORS-1:0])
    else $error("volatile guard kept");
  c_unlock: cover property (wc(spl_pkg::CMD_UNLOCK));
  c_perr: cover property (rd(spl_pkg::ADDR_STATUS) && d[1]);
  c_mode: cover property (wc(spl_pkg::CMD_MODE_PROG));
endmodule

//--- tb/spl_host.sv
// Host controller model driving the protection registers over APB
`timescale 1ns/1ps
module spl_host (
  input  wire logic                  sys_clk,
  output      spl_pkg::spl_apb_req_s apbReq,
  input  wire spl_pkg::spl_apb_rsp_s apbRsp
);
  initial apbReq = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
    @(posedge sys_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do @(posedge sys_clk); while (apbRsp.pready !== 1'b1);
    rv = apbRsp.prdata;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  // Bounded so a stuck busy flag ends as a count, not a hang
  task automatic poll(output int n);
    logic [31:0] s;
    n = 0;
    do begin
      xfer(1'b0, spl_pkg::ADDR_STATUS, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 60);
  endtask
endmodule

//--- tb/spl_sector_protect_tb.sv
// Testbench of the sector protect lock block against a behavioural model
`timescale 1ns/1ps
module spl_sector_protect_tb;
  logic                  sys_clk;
  logic                  nrst;
  logic                  hwResetN;
  logic                  readProtectActive;
  logic [4:0]            eccAccessSector;
  logic [31:0]           eccSectorFlags;
  logic [31:0]           sectorWritable;
  spl_pkg::spl_apb_req_s apbReq;
  spl_pkg::spl_apb_rsp_s apbRsp;
  logic [31:0]           nvM, volM, seed, r, lo;
  logic                  lockM, perrM;
  logic [1:0]            modeM;
  logic [63:0]           pwdM;
  int                    mismatches = 0, numChecks = 0, cyc = 0, n;
  spl_sector_protect #(.NUM_SECTORS(32), .UNLOCK_GAP_CYC(20)) spl_sector_protect_inst (.sys_clk(sys_clk),
    .nrst(nrst), .hwResetN(hwResetN), .apbReq(apbReq), .apbRsp(apbRsp), .readProtectActive(readProtectActive),
    .eccAccessSector(eccAccessSector), .eccSectorFlags(eccSectorFlags), .sectorWritable(sectorWritable));
  spl_host spl_host_inst (.sys_clk(sys_clk), .apbReq(apbReq), .apbRsp(apbRsp));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      testDone();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic testDone;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    spl_host_inst.xfer(1'b1, a, dv, r);
  endtask
  task automatic rd(input logic [7:0] a);
    spl_host_inst.xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic cmd(input logic [3:0] c, input logic v, input logic [4:0] s, input logic [1:0] m);
    wr(spl_pkg::ADDR_CMD, {14'h0, m, 3'h0, s, 3'h0, v, c});
  endtask
  task automatic checkAll;
    rd(spl_pkg::ADDR_PROTMAP);
    chk("volGuard", volM, r);
    rd(spl_pkg::ADDR_SECTOR);
    chk("nvGuard", nvM, r);
    chk("writable", nvM & volM, sectorWritable);
    rd(spl_pkg::ADDR_STATUS);
    chk("status", {27'h0, modeM, lockM, perrM, 1'b0}, r);
  endtask
  task automatic hwPulse;
    @(posedge sys_clk) hwResetN <= 1'b0;
    @(posedge sys_clk) hwResetN <= 1'b1;
  endtask
  task automatic pwdCheck(input logic [63:0] e);
    wr(spl_pkg::ADDR_PWD_LO, 32'h0);
    wr(spl_pkg::ADDR_PWD_HI, 32'h0);
    cmd(spl_pkg::CMD_PWD_READ, 1'b0, 5'h0, 2'h0);
    rd(spl_pkg::ADDR_PWD_LO);
    chk("pwdLo", e[31:0], r);
    rd(spl_pkg::ADDR_PWD_HI);
    chk("pwdHi", e[63:32], r);
  endtask
  task automatic unlock(input logic [63:0] p);
    wr(spl_pkg::ADDR_PWD_LO, p[31:0]);
    wr(spl_pkg::ADDR_PWD_HI, p[63:32]);
    cmd(spl_pkg::CMD_UNLOCK, 1'b0, 5'h0, 2'h0);
  endtask
  initial begin
    nrst              = 1'b0;
    hwResetN          = 1'b1;
    readProtectActive = 1'b0;
    eccAccessSector   = 5'h0;
    eccSectorFlags    = 32'h0;
    seed              = 32'hf989;
    nvM               = '1;
    volM              = '1;
    lockM             = 1'b1;
    perrM             = 1'b0;
    modeM             = spl_pkg::MODE_DEFAULT;
    pwdM              = spl_pkg::PWD_RESET;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    checkAll();
    rd(8'h24);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge sys_clk);
      eccSectorFlags    <= seed;
      eccAccessSector   <= seed[12:8];
      readProtectActive <= i[0];
      rd(spl_pkg::ADDR_ECC);
      chk("ecc", {31'h0, i[0] ? seed[0] : seed[seed[12:8]]}, {31'h0, r[0]});
    end
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      cmd(seed[8] ? spl_pkg::CMD_VOL_WRITE : spl_pkg::CMD_NV_PROGRAM, seed[9], seed[4:0], 2'h0);
      if (seed[8]) volM[seed[4:0]] = seed[9];
      else nvM[seed[4:0]] = 1'b0;
      checkAll();
    end
    cmd(spl_pkg::CMD_NV_ERASE, 1'b0, 5'h0, 2'h0);
    nvM = '1;
    cmd(spl_pkg::CMD_NV_PROGRAM, 1'b0, 5'h5, 2'h0);
    nvM[5] = 1'b0;
    // Guards configured first, then frozen
    cmd(spl_pkg::CMD_LOCK_CLEAR, 1'b0, 5'h0, 2'h0);
    lockM = 1'b0;
    checkAll();
    cmd(spl_pkg::CMD_NV_ERASE, 1'b0, 5'h0, 2'h0);
    // Refused erase reports a program error
    perrM = 1'b1;
    cmd(spl_pkg::CMD_VOL_WRITE, 1'b0, 5'h6, 2'h0);
    volM[6] = 1'b0;
    checkAll();
    cmd(spl_pkg::CMD_SOFT_RESET, 1'b0, 5'h0, 2'h0);
    volM = '1;
    perrM = 1'b0;
    checkAll();
    cmd(spl_pkg::CMD_VOL_WRITE, 1'b0, 5'h7, 2'h0);
    hwPulse();
    lockM = 1'b1;
    checkAll();
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      lo   = seed;
      seed = xs(seed);
      wr(spl_pkg::ADDR_PWD_LO, lo);
      wr(spl_pkg::ADDR_PWD_HI, seed);
      cmd(spl_pkg::CMD_PWD_PROG, 1'b0, 5'h0, 2'h0);
      pwdM = pwdM & {seed, lo};
    end
    pwdCheck(pwdM);
    for (int i = 0; i < 3; i++) begin
      cmd(spl_pkg::CMD_MODE_PROG, 1'b0, 5'h0, 2'(i));
      if (i == 1) modeM = spl_pkg::MODE_PASSWORD;
      // Illegal code and a second selection both fail
      perrM = (i != 1);
      checkAll();
      cmd(spl_pkg::CMD_CLEAR_ERR, 1'b0, 5'h0, 2'h0);
      perrM = 1'b0;
    end
    wr(spl_pkg::ADDR_PWD_LO, 32'h0);
    wr(spl_pkg::ADDR_PWD_HI, 32'h0);
    cmd(spl_pkg::CMD_PWD_PROG, 1'b0, 5'h0, 2'h0);
    pwdCheck(64'h0);
    hwPulse();
    lockM = 1'b0;
    checkAll();
    unlock({pwdM[63:32] ^ 32'h80000000, pwdM[31:0]});
    rd(spl_pkg::ADDR_STATUS);
    chk("mismatch", {27'h0, modeM, 3'h3}, r);
    cmd(spl_pkg::CMD_CLEAR_ERR, 1'b0, 5'h0, 2'h0);
    spl_host_inst.poll(n);
    chk("gap", 32'h1, {31'h0, n >= 3 && n <= 7});
    checkAll();
    unlock(pwdM);
    spl_host_inst.poll(n);
    chk("fast", 32'h1, {31'h0, n <= 2});
    lockM = 1'b1;
    checkAll();
    cmd(spl_pkg::CMD_LOCK_CLEAR, 1'b0, 5'h0, 2'h0);
    lockM = 1'b0;
    checkAll();
    testDone();
  end
endmodule
bind spl_sector_protect spl_sector_protect_chk #(.NUM_SECTORS(NUM_SECTORS)) spl_sector_protect_chk_inst (
  .sys_clk(sys_clk), .nrst(nrst), .hwResetN(hwResetN), .apbReq(apbReq), .apbRsp(apbRsp),
  .readProtectActive(readProtectActive), .eccAccessSector(eccAccessSector), .eccSectorFlags(eccSectorFlags),
  .sectorWritable(sectorWritable));
